// [hdl/uspbg_pkg.sv]
/*
 * Constants, register map and state encodings for the serial port with
 * baud generation. Assumes a single core clock and a 32-bit Avalon-MM
 * register bus with byte addresses.
 */
package uspbg_pkg;

	// Register map (byte addresses)
	localparam int         ADDR_W     = 4;
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] DATA_OFS   = 4'h4;
	localparam logic [3:0] BAUD_OFS   = 4'h8;
	localparam logic [3:0] RELOAD_OFS = 4'hC;

	// Control register fields
	localparam int MODE0_BIT = 7;
	localparam int MODE1_BIT = 6;
	localparam int MPE_BIT   = 5;
	localparam int REN_BIT   = 4;
	localparam int TB8_BIT   = 3;
	localparam int RB8_BIT   = 2;
	localparam int TI_BIT    = 1;
	localparam int RI_BIT    = 0;

	// Baud select register fields
	localparam int DRATE_BIT  = 0;
	localparam int TRANSMIT_CLOCK_SELECT_BIT   = 1;
	localparam int RCLK_BIT   = 2;
	localparam int TXBUSY_BIT = 4;
	localparam int RXBUSY_BIT = 5;

	// Reload register fields
	localparam int T2L_LSB = 0;
	localparam int T2H_LSB = 8;

	// Reset values
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [15:0] RELOAD_RST = 16'h0000;

	// Timing: divisors of the core clock and oversampling
	localparam int         OVERSAMPLE   = 16;
	localparam int         M0_DIV       = 12;
	localparam int         M2_DIV_SLOW  = 64;
	localparam int         M2_DIV_FAST  = 32;
	localparam int         M2_PRE_SPAN  = 4;
	localparam logic [3:0] MID_SAMPLE   = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [3:0] M0_RLD       = 4'(OVERSAMPLE - M0_DIV);
	localparam logic [3:0] M0_RISE      = 4'(OVERSAMPLE - M0_DIV / 2);
	localparam logic [3:0] M0_RISE_PRE  = 4'(OVERSAMPLE - M0_DIV / 2 - 1);
	localparam logic [3:0] DIV_RLD      = 4'h0;
	localparam logic [1:0] M2_RLD_SLOW  =
		2'(M2_PRE_SPAN - M2_DIV_SLOW / OVERSAMPLE);
	localparam logic [1:0] M2_RLD_FAST  =
		2'(M2_PRE_SPAN - M2_DIV_FAST / OVERSAMPLE);

	// Frame lengths in bits
	localparam logic [3:0] DATA_BITS   = 4'h8;
	localparam logic [3:0] FRAME8_BITS = 4'hA;
	localparam logic [3:0] FRAME9_BITS = 4'hB;

	typedef enum logic [1:0] {
		MODE_SHIFT  = 2'h0,
		MODE_UART8  = 2'h1,
		MODE_FIXED9 = 2'h2,
		MODE_VAR9   = 2'h3
	} uspbg_mode_t;

	typedef enum logic [3:0] {
		TX_IDLE   = 4'b0001,
		TX_LOAD   = 4'b0010,
		TX_ASYNC  = 4'b0100,
		TX_SHIFT0 = 4'b1000
	} uspbg_tx_t;

	typedef enum logic [4:0] {
		RX_IDLE   = 5'b00001,
		RX_START  = 5'b00010,
		RX_DATA   = 5'b00100,
		RX_STOP   = 5'b01000,
		RX_SHIFT0 = 5'b10000
	} uspbg_rx_t;

endpackage

// [hdl/uspbg_reload_cnt.sv]
/*
 * Reload counter: counts up on each step, flags the wrap from all ones
 * and reloads. Period in steps is two to the W minus the reload value.
 * Assumes the reload value is held stable by the caller.
 */
`timescale 1ns/1ps
module uspbg_reload_cnt #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Control
	input  wire logic         restart,
	input  wire logic         step,
	input  wire logic [W-1:0] reload,
	// Status
	output logic      [W-1:0] count,
	output logic              wrap
);
	logic [W-1:0] next_count;

	// Wrap marks the step that leaves the all-ones value
	assign wrap = step & (&count);

	// Restart takes priority so a frame always begins on a clean phase
	always_comb begin
		next_count = count;
		if (restart) begin
			next_count = reload;
		end else if (wrap) begin
			next_count = reload;
		end else if (step) begin
			next_count = count + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Count takes the reload value after a wrap that has no restart
	a_wrap_reload: assert property (@(posedge clk) disable iff (!resetn)
		(wrap && !restart) |=> count == $past(reload))
		else $error("reload counter did not reload on wrap");
endmodule

// [hdl/uspbg_top.sv]
/*
 * Full-duplex serial port: shift-register mode, 8-bit and 9-bit UART
 * modes, baud timing from the core clock, a timer 1 overflow pulse or an
 * internal timer 2 baud generator. Assumes an Avalon-MM master on the
 * core clock and a timer 1 outside the block that pulses on overflow.
 */
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Function
// [R1] Shift mode receive starts only with receive enabled and flag clear.
// [R2] Mode 1 frame: start 0, eight bits LSB first, stop 1.
// [R3] Mode 1 rate follows timer 1 or timer 2, per direction.
// [R4] Write starts mode 1 send; stop bit 1; done flag at stop.
// [R5] Async receiver starts on falling edge, skips start, takes bits.
// [R6] Mode 1 final shift loads buffer, stop bit, flag if accepted.
// [R7] Mode 2 rate is clock over 64, or 32 with double rate.
// [R8] Modes 2 and 3 frame: start, eight bits, ninth bit, stop.
// [R9] Nine-bit send loads byte and ninth bit, starts at next tick.
// [R10] Nine-bit receive latches byte and ninth bit when accepted.
// [R11] Mode 3 is the nine-bit frame at the mode 1 rate.
// [R12] Any data write sends; async receive needs receive enable.
// [R13] Shift mode bit rate is core clock over 12.
// [R14] Timer 1 rate is overflow rate times double factor over 32.
// [R15] Software disables timer 1 interrupt and sets its reload.
// [R16] Timer 2 rate is overflow over 16, counting every two clocks.
// [R17] Timer 2 select bits make it the baud generator per direction.
// [R18] Transmit and receive may run at different rates at once.
// [R19] Multiprocessor receive with ninth bit 0 raises no flag.
// [R20] Flags are set by hardware only and cleared by software; a control write here can also set them.
// [R21] Data write loads transmit; read returns separate receive buffer.
// [R22] Receive line synchronised; start checked at mid-bit of sixteen.
module uspbg_top (
	// Clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         resetn,
	// Avalon-MM slave
	input  wire logic [uspbg_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [3:0]                   avs_byteenable,
	input  wire logic [31:0]                  avs_writedata,
	output logic      [31:0]                  avs_readdata,
	output logic                              avs_waitrequest,
	// Baud source
	input  wire logic                         timer1_overflow,
	// Serial pins
	input  wire logic                         rxd_in,
	output logic                              rxd_out,
	output logic                              rxd_oe_n,
	output logic                              txd_out
);
	import uspbg_pkg::*;

	logic        req, ack, next_ack;
	logic [31:0] next_rdata;
	logic        wr_ctrl, wr_data, wr_baud;
	logic [1:0]  wr_rld;
	uspbg_mode_t mode, next_mode;
	logic        mpe, ren, tb8, rb8, ti, ri, double_rate_bit, transmit_clock_select, rclk;
	logic        next_mpe, next_ren, next_tb8, next_rb8, next_ti, next_ri;
	logic        next_double_rate_bit, next_transmit_clock_select, next_rclk;
	logic [15:0] t2_reload, next_t2_reload;
	logic [7:0]  rx_buf, next_rx_buf;
	logic        set_ti, set_ri, ld_rx, ld_rx9;
	logic        rx_meta, rx_sync, rx_prev, rx_fall;
	logic        t1half, t2half, t1_tick, t2_step, t2_ovf, m2_tick;
	logic        tx_sample, rx_sample, tx_bit, rx_mid, rx_restart;
	logic [3:0]  rx_div_cnt, m0_cnt;
	logic        m0_wrap, tx_m0_go, rx_m0_go, m0_restart, m0_clk;
	uspbg_tx_t   tx_state, next_tx_state;
	logic [10:0] tx_frame, next_tx_frame;
	logic [3:0]  tx_cnt, next_tx_cnt, nbits;
	logic        txd, next_txd;
	uspbg_rx_t   rx_state, next_rx_state;
	logic [8:0]  rx_sh, next_rx_sh;
	logic [3:0]  rx_cnt, next_rx_cnt;

	// Bus: one wait cycle, so read data is registered before it is taken
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack;
	assign next_ack        = req & ~ack;
	assign wr_ctrl = avs_write & ack & avs_byteenable[0]
		& (avs_address == CTRL_OFS);
	assign wr_data = avs_write & ack & avs_byteenable[0]
		& (avs_address == DATA_OFS);
	assign wr_baud = avs_write & ack & avs_byteenable[0]
		& (avs_address == BAUD_OFS);
	assign wr_rld  = {2{avs_write & ack & (avs_address == RELOAD_OFS)}}
		& avs_byteenable[1:0];

	// Read mux; unmapped addresses read as zero
	always_comb begin
		next_rdata = '0;
		case (avs_address)
			CTRL_OFS: next_rdata[7:0] = {mode, mpe, ren, tb8, rb8, ti, ri};
			DATA_OFS: next_rdata[7:0] = rx_buf; // see [R21]
			BAUD_OFS: begin
				next_rdata[DRATE_BIT]  = double_rate_bit;
				next_rdata[TRANSMIT_CLOCK_SELECT_BIT]   = transmit_clock_select;
				next_rdata[RCLK_BIT]   = rclk;
				next_rdata[TXBUSY_BIT] = (tx_state != TX_IDLE);
				next_rdata[RXBUSY_BIT] = (rx_state != RX_IDLE);
			end
			RELOAD_OFS: next_rdata[15:0] = t2_reload;
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ack          <= 1'b0;
			avs_readdata <= '0;
		end else begin
			ack          <= next_ack;
			avs_readdata <= next_rdata;
		end
	end

	// Software registers; hardware set wins over a software clear
	always_comb begin
		next_mode = mode;
		next_mpe  = mpe;
		next_ren  = ren;
		next_tb8  = tb8;
		next_rb8  = rb8;
		next_ti   = ti;
		next_ri   = ri;
		next_double_rate_bit = double_rate_bit;
		next_transmit_clock_select = transmit_clock_select;
		next_rclk = rclk;
		next_t2_reload = t2_reload;
		next_rx_buf    = rx_buf;
		if (wr_ctrl) begin
			next_mode = uspbg_mode_t'({avs_writedata[MODE0_BIT],
				avs_writedata[MODE1_BIT]}); // see [R11]
			next_mpe = avs_writedata[MPE_BIT];
			next_ren = avs_writedata[REN_BIT];
			next_tb8 = avs_writedata[TB8_BIT];
			next_rb8 = avs_writedata[RB8_BIT];
			next_ti  = avs_writedata[TI_BIT];
			next_ri  = avs_writedata[RI_BIT];
		end
		if (wr_baud) begin
			next_double_rate_bit = avs_writedata[DRATE_BIT];
			next_transmit_clock_select = avs_writedata[TRANSMIT_CLOCK_SELECT_BIT];
			next_rclk = avs_writedata[RCLK_BIT];
		end
		if (wr_rld[0]) begin
			next_t2_reload[7:0] = avs_writedata[T2L_LSB +: 8];
		end
		if (wr_rld[1]) begin
			next_t2_reload[15:8] = avs_writedata[T2H_LSB +: 8];
		end
		if (set_ti) begin
			next_ti = 1'b1; // see [R20]
		end
		if (set_ri) begin
			next_ri = 1'b1; // see [R20]
		end
		if (ld_rx) begin
			next_rx_buf = rx_sh[8:1]; // see [R6] see [R10]
		end
		if (ld_rx9) begin
			next_rb8 = rx_sync; // see [R6] see [R10]
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode      <= uspbg_mode_t'(CTRL_RST[MODE0_BIT -: 2]);
			mpe       <= CTRL_RST[MPE_BIT];
			ren       <= CTRL_RST[REN_BIT];
			tb8       <= CTRL_RST[TB8_BIT];
			rb8       <= CTRL_RST[RB8_BIT];
			ti        <= CTRL_RST[TI_BIT];
			ri        <= CTRL_RST[RI_BIT];
			double_rate_bit      <= 1'b0;
			transmit_clock_select      <= 1'b0;
			rclk      <= 1'b0;
			t2_reload <= RELOAD_RST;
			rx_buf    <= '0;
		end else begin
			mode      <= next_mode;
			mpe       <= next_mpe;
			ren       <= next_ren;
			tb8       <= next_tb8;
			rb8       <= next_rb8;
			ti        <= next_ti;
			ri        <= next_ri;
			double_rate_bit      <= next_double_rate_bit;
			transmit_clock_select      <= next_transmit_clock_select;
			rclk      <= next_rclk;
			t2_reload <= next_t2_reload;
			rx_buf    <= next_rx_buf;
		end
	end

	// Synchroniser and halving toggles; rx_meta feeds rx_sync only
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
			t1half  <= 1'b0;
			t2half  <= 1'b0;
		end else begin
			rx_meta <= rxd_in; // see [R22]
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
			t1half  <= t1half ^ timer1_overflow;
			t2half  <= ~t2half;
		end
	end

	// Sample ticks at sixteen per bit, chosen per direction
	assign rx_fall   = rx_prev & ~rx_sync; // see [R5]
	assign t1_tick   = timer1_overflow & (double_rate_bit | t1half); // see [R14]
	assign t2_step   = (transmit_clock_select | rclk) & t2half; // see [R16] see [R17]
	assign tx_sample = (mode == MODE_FIXED9) ? m2_tick
		: (transmit_clock_select ? t2_ovf : t1_tick); // see [R3] see [R18]
	assign rx_sample = (mode == MODE_FIXED9) ? m2_tick
		: (rclk ? t2_ovf : t1_tick); // see [R3] see [R18]
	assign rx_mid     = rx_sample & (rx_div_cnt == MID_SAMPLE);
	assign m0_restart = tx_m0_go | rx_m0_go;
	// Shift clock low in the first half of each bit, rising mid-bit
	assign m0_clk = m0_restart ? 1'b0
		: ((m0_cnt >= M0_RISE_PRE) && !m0_wrap);

	uspbg_reload_cnt #(.W(2)) u_m2_pre ( // see [R7]
		.clk(ref_clk), .resetn(resetn), .restart(1'b0), .step(1'b1),
		.reload(double_rate_bit ? M2_RLD_FAST : M2_RLD_SLOW),
		.count(), .wrap(m2_tick));
	// Held at reload outside baud mode, else the first overflow waits
	// for a full 16-bit wrap from zero
	uspbg_reload_cnt #(.W(16)) u_timer2 ( // see [R17]
		.clk(ref_clk), .resetn(resetn), .restart(~(transmit_clock_select | rclk)),
		.step(t2_step),
		.reload(t2_reload), .count(), .wrap(t2_ovf));
	uspbg_reload_cnt #(.W(4)) u_tx_div (
		.clk(ref_clk), .resetn(resetn), .restart(1'b0), .step(tx_sample),
		.reload(DIV_RLD), .count(), .wrap(tx_bit));
	uspbg_reload_cnt #(.W(4)) u_rx_div ( // see [R22]
		.clk(ref_clk), .resetn(resetn), .restart(rx_restart),
		.step(rx_sample), .reload(DIV_RLD), .count(rx_div_cnt),
		.wrap());
	uspbg_reload_cnt #(.W(4)) u_m0_div ( // see [R13]
		.clk(ref_clk), .resetn(resetn), .restart(m0_restart),
		.step(1'b1), .reload(M0_RLD), .count(m0_cnt), .wrap(m0_wrap));

	// Transmitter; a write while busy restarts with the new byte
	assign nbits = (mode == MODE_UART8) ? FRAME8_BITS : FRAME9_BITS;
	always_comb begin
		next_tx_state = tx_state;
		next_tx_frame = tx_frame;
		next_tx_cnt   = tx_cnt;
		next_txd      = txd;
		set_ti        = 1'b0;
		tx_m0_go      = 1'b0;
		if (wr_data) begin
			next_tx_state = TX_LOAD; // see [R12] see [R21]
			next_tx_cnt   = '0;
			if (mode == MODE_SHIFT) begin
				next_tx_frame = {3'b111, avs_writedata[7:0]};
			end else begin
				next_tx_frame = {1'b1, (mode == MODE_UART8) | tb8,
					avs_writedata[7:0], 1'b0}; // see [R2] see [R4] see [R8]
			end
		end else begin
			case (tx_state)
				TX_IDLE: next_txd = (rx_state == RX_SHIFT0) ? m0_clk : 1'b1;
				TX_LOAD: begin
					if (mode == MODE_SHIFT) begin
						if (rx_state != RX_SHIFT0) begin
							tx_m0_go      = 1'b1;
							next_txd      = 1'b0;
							next_tx_state = TX_SHIFT0;
						end
					end else if (tx_bit) begin
						next_txd      = tx_frame[0]; // see [R9]
						next_tx_frame = {1'b1, tx_frame[10:1]};
						next_tx_cnt   = 4'h1;
						next_tx_state = TX_ASYNC;
					end
				end
				TX_ASYNC: begin
					if (tx_bit) begin
						if (tx_cnt == nbits) begin
							next_txd      = 1'b1;
							next_tx_state = TX_IDLE;
						end else begin
							next_txd      = tx_frame[0];
							next_tx_frame = {1'b1, tx_frame[10:1]};
							next_tx_cnt   = tx_cnt + 4'h1;
							set_ti = (tx_cnt == nbits - 4'h1); // see [R4] see [R9]
						end
					end
				end
				TX_SHIFT0: begin
					next_txd = m0_clk;
					if (m0_wrap) begin
						next_tx_frame = {1'b1, tx_frame[10:1]};
						next_tx_cnt   = tx_cnt + 4'h1;
						if (tx_cnt == DATA_BITS - 4'h1) begin
							set_ti        = 1'b1;
							next_txd      = 1'b1;
							next_tx_state = TX_IDLE;
						end
					end
				end
				default: next_tx_state = TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_state <= TX_IDLE;
			tx_frame <= '1;
			tx_cnt   <= '0;
			txd      <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			tx_frame <= next_tx_frame;
			tx_cnt   <= next_tx_cnt;
			txd      <= next_txd;
		end
	end

	// Shift mode drives data on the receive pin, clock on transmit pin
	assign txd_out  = txd;
	assign rxd_out  = tx_frame[0];
	assign rxd_oe_n = (tx_state != TX_SHIFT0);

	// Receiver; frame is dropped when the flag is still set
	always_comb begin
		next_rx_state = rx_state;
		next_rx_sh    = rx_sh;
		next_rx_cnt   = rx_cnt;
		set_ri        = 1'b0;
		ld_rx         = 1'b0;
		ld_rx9        = 1'b0;
		rx_m0_go      = 1'b0;
		rx_restart    = 1'b0;
		case (rx_state)
			RX_IDLE: begin
				if (mode == MODE_SHIFT) begin
					if (ren && !ri && tx_state == TX_IDLE && !wr_data) begin
						rx_m0_go      = 1'b1; // see [R1]
						next_rx_cnt   = '0;
						next_rx_state = RX_SHIFT0;
					end
				end else if (ren && rx_fall) begin
					rx_restart    = 1'b1; // see [R5] see [R12]
					next_rx_state = RX_START;
				end
			end
			RX_START: begin
				if (rx_mid) begin
					next_rx_cnt   = '0;
					next_rx_state = rx_sync ? RX_IDLE : RX_DATA; // see [R22]
				end
			end
			RX_DATA: begin
				if (rx_mid) begin
					next_rx_sh  = {rx_sync, rx_sh[8:1]};
					next_rx_cnt = rx_cnt + 4'h1;
					if (rx_cnt == DATA_BITS) begin
						// Ninth bit is the stop bit in mode 1
						if (!ri && (!mpe || rx_sync)) begin // see [R19]
							ld_rx  = 1'b1; // see [R6] see [R10]
							ld_rx9 = 1'b1;
							set_ri = 1'b1;
						end
						next_rx_state = (mode == MODE_UART8) ? RX_IDLE : RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_mid) begin
					next_rx_state = RX_IDLE;
				end
			end
			RX_SHIFT0: begin
				if (m0_cnt == M0_RISE) begin
					next_rx_sh  = {rx_sync, rx_sh[8:1]}; // see [R1]
					next_rx_cnt = rx_cnt + 4'h1;
				end
				if (m0_wrap && rx_cnt == DATA_BITS) begin
					ld_rx         = 1'b1;
					set_ri        = 1'b1;
					next_rx_state = RX_IDLE;
				end
			end
			default: next_rx_state = RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_state <= RX_IDLE;
			rx_sh    <= '0;
			rx_cnt   <= '0;
		end else begin
			rx_state <= next_rx_state;
			rx_sh    <= next_rx_sh;
			rx_cnt   <= next_rx_cnt;
		end
	end

	// Checks on the engines
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_stop_sets_ti: assert property ( // see [R4]
		(tx_state == TX_ASYNC && tx_bit && !wr_data
			&& tx_cnt == nbits - 4'h1) |=> (ti && txd_out))
		else $error("stop bit did not raise transmit flag");
	a_start_bit_out: assert property ( // see [R9]
		(tx_state == TX_LOAD && tx_bit && !wr_data
			&& mode != MODE_SHIFT) |=> !txd_out)
		else $error("start bit not driven at baud tick");
	a_write_starts: assert property ( // see [R12]
		wr_data |=> tx_state == TX_LOAD)
		else $error("data write did not start transmission");
	a_flag_sticky: assert property ( // see [R20]
		(ti && !wr_ctrl) |=> ti)
		else $error("transmit flag cleared without software");
	a_m0_rx_start: assert property ( // see [R1]
		(rx_state == RX_IDLE && mode == MODE_SHIFT && ren && !ri
			&& tx_state == TX_IDLE && !wr_data) |=> rx_state == RX_SHIFT0)
		else $error("shift mode reception did not start");
	a_rx_need_ren: assert property ( // see [R12]
		(rx_state == RX_IDLE && !ren) |=> rx_state == RX_IDLE)
		else $error("receiver started while disabled");
	a_bad_start: assert property ( // see [R22]
		(rx_state == RX_START && rx_mid && rx_sync) |=> rx_state == RX_IDLE)
		else $error("false start bit not rejected");
	a_mp_reject: assert property ( // see [R19]
		(rx_state == RX_DATA && rx_mid && rx_cnt == DATA_BITS && mpe
			&& !rx_sync && !ri && !wr_ctrl) |=> !ri)
		else $error("multiprocessor frame raised receive flag");
	a_rx_load: assert property ( // see [R6]
		(rx_state == RX_DATA && rx_mid && rx_cnt == DATA_BITS && !ri
			&& !mpe) |=> (ri && rx_buf == $past(rx_sh[8:1])
			&& rb8 == $past(rx_sync)))
		else $error("received byte not latched");
	a_m2_rate: assert property ( // see [R7]
		(m2_tick && !double_rate_bit && !$past(double_rate_bit)) |=> !m2_tick [*3] ##1 m2_tick)
		else $error("mode 2 prescale period wrong");
	a_m0_period: assert property (disable iff (!resetn || m0_restart)
		m0_wrap |=> !m0_wrap [*8] ##1 !m0_wrap [*3] ##1 m0_wrap) // see [R13]
		else $error("shift mode bit period not twelve clocks");

	c_tx_frame: cover property (tx_state == TX_ASYNC ##1 set_ti);
	c_rx_accept: cover property (set_ri && rx_state == RX_DATA);
	c_m0_rx_done: cover property (rx_state == RX_SHIFT0 && set_ri);
	c_mp_drop: cover property (rx_state == RX_DATA && rx_cnt == DATA_BITS
		&& rx_mid && mpe && !rx_sync);
endmodule

// [tb/uspbg_remote.sv]
/*
 * Remote serial port: captures frames from the transmit pin and sends
 * frames onto the receive pin. Assumes the bench sets the bit period.
 */
`timescale 1ns/1ps
module uspbg_remote (
	// Clock and pins
	input  wire logic               clk,
	input  wire logic               txd,
	input  wire logic               sdata,
	input  wire logic               sdata_oe_n,
	output logic                    rxd,
	// Bit period in clocks, frame length in bits; below 2 no async capture
	input  wire logic signed [31:0] bit_clks,
	input  wire logic signed [31:0] nbits,
	// Captured frame, start bit dropped
	output logic                    got,
	output logic [9:0]              got_data
);
	int i;
	// Capture at mid-bit; start bit, LSB first, stop last
	initial begin
		rxd = 1'b1;
		got = 1'b0;
		got_data = '0;
		forever begin
			@(negedge txd);
			@(posedge clk);
			got_data = '0;
			if (!sdata_oe_n) begin
				// Shift mode: data valid at each rising shift clock
				for (i = 0; i < 8; i++) begin
					@(posedge txd);
					got_data[i] = sdata;
				end
				got <= 1'b1;
			end else if (nbits > 1) begin
				repeat (bit_clks / 2 - 1) @(posedge clk);
				for (i = 0; i < nbits - 1; i++) begin
					repeat (bit_clks) @(posedge clk);
					got_data[i] = txd;
				end
				got <= 1'b1;
			end
			@(posedge clk);
			got <= 1'b0;
		end
	end
	// Send start, the given bits, then idle high (pulled up)
	task automatic send(input logic [9:0] b, input int n);
		int k;
		@(posedge clk);
		rxd <= 1'b0;
		for (k = 0; k < n; k++) begin
			repeat (bit_clks) @(posedge clk);
			rxd <= b[k];
		end
		repeat (bit_clks) @(posedge clk);
		rxd <= 1'b1;
	endtask
endmodule

// [tb/uspbg_top_test.sv]
/*
 * Self-checking bench for the serial port: Avalon-MM register traffic
 * and frames through the remote model. Assumes the package constants.
 */
`timescale 1ns/1ps
module uspbg_top_test;
	import uspbg_pkg::*;
	logic        ref_clk, resetn, rd, wr, t1ov, rxd, got;
	logic        waitreq, rxd_out, rxd_oe_n, txd;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, rd_val;
	logic [9:0]  got_data;
	logic [7:0]  b0, b1;
	logic        n9;
	int          fails, num_checks, bitc, nb, t1per;
	int          cnt = 0;
	logic [31:0] exp_rd[$];
	logic [9:0]  exp_fr[$];
	event        rd_ev;

	uspbg_top dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(addr),
		.avs_read(rd), .avs_write(wr), .avs_byteenable(4'hF),
		.avs_writedata(wdata), .avs_readdata(rdata),
		.avs_waitrequest(waitreq), .timer1_overflow(t1ov), .rxd_in(rxd),
		.rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_out(txd));
	uspbg_remote rem (.clk(ref_clk), .txd(txd), .rxd(rxd),
		.sdata(rxd_out), .sdata_oe_n(rxd_oe_n),
		.bit_clks(bitc), .nbits(nb), .got(got), .got_data(got_data));

	// 40 MHz core clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Timer 1 overflow every t1per clocks, interrupt left off
	always @(posedge ref_clk) begin
		cnt <= (cnt + 1) % t1per;
		t1ov <= (cnt == 0);
	end
	// Oldest noted result against what appeared
	always @(rd_ev) begin
		num_checks++;
		if (exp_rd.size() == 0 || rd_val !== exp_rd[0]) begin
			fails++;
			$display("unexpected read at %0t: %h", $time, rd_val);
		end
		if (exp_rd.size() != 0) void'(exp_rd.pop_front());
	end
	always @(posedge got) begin
		num_checks++;
		if (exp_fr.size() == 0 || got_data !== exp_fr[0]) begin
			fails++;
			$display("unexpected frame at %0t: %h", $time, got_data);
		end
		if (exp_fr.size() != 0) void'(exp_fr.pop_front());
	end

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One Avalon-MM transfer; held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		rd_val = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (!w) ->rd_ev;
		if (n >= 50) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic rdx(input logic [3:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	// Send a byte, wait for the remote to capture it
	task automatic tx(input logic [7:0] b, input logic [9:0] e);
		int n;
		n = 0;
		exp_fr.push_back(e);
		bus(1'b1, DATA_OFS, {24'h00_0000, b});
		while (exp_fr.size() != 0 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 3000) begin
			fails++;
			report_and_stop();
		end
	endtask

	initial begin
		{rd, wr, fails, num_checks} = '0;
		{addr, wdata} = '0;
		t1per = 4;
		bitc = 64;
		nb = 11;
		resetn = 1'b0;
		void'($urandom(83540));
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rdx(CTRL_OFS, 32'h0000_0000);
		rdx(RELOAD_OFS, 32'h0000_0000);
		rdx(4'h2, 32'h0000_0000);
		// Mode 2 send at both fixed rates, random ninth bit
		for (int s = 0; s < 2; s++) begin
			b0 = 8'($urandom);
			n9 = 1'($urandom);
			bitc = s ? 32 : 64;
			bus(1'b1, BAUD_OFS, 32'(s));
			bus(1'b1, CTRL_OFS, {24'h0, 4'h8, n9, 3'h0});
			tx(b0, {1'b1, n9, b0});
			rdx(CTRL_OFS, {24'h0, 4'h8, n9, 3'h2});
		end
		// Mode 2 receive, then overrun and multiprocessor filtering
		b0 = 8'($urandom);
		b1 = ~b0;
		bus(1'b1, CTRL_OFS, 32'h0000_0090);
		rem.send({1'b1, 1'b1, b0}, 10);
		rdx(DATA_OFS, {24'h0, b0});
		rdx(CTRL_OFS, 32'h0000_0095);
		rem.send({1'b1, 1'b1, b1}, 10);
		rdx(DATA_OFS, {24'h0, b0});
		bus(1'b1, CTRL_OFS, 32'h0000_00B4);
		rem.send({1'b1, 1'b0, b1}, 10);
		rdx(CTRL_OFS, 32'h0000_00B4);
		rem.send({1'b1, 1'b1, b1}, 10);
		rdx(DATA_OFS, {24'h0, b1});
		// Mode 1 on timer 2, reload all ones gives 32 clocks a bit
		bitc = 32;
		nb = 10;
		b0 = 8'($urandom);
		bus(1'b1, RELOAD_OFS, 32'h0000_FFFF);
		bus(1'b1, BAUD_OFS, 32'h0000_0006);
		bus(1'b1, CTRL_OFS, 32'h0000_0050);
		tx(b0, {2'b01, b0});
		rem.send({2'b01, ~b0}, 9);
		rdx(DATA_OFS, {24'h0, ~b0});
		rdx(CTRL_OFS, 32'h0000_0057);
		// Mode 3: send on timer 2, receive on timer 1 at another rate
		nb = 11;
		b0 = 8'($urandom);
		bus(1'b1, BAUD_OFS, 32'h0000_0003);
		bus(1'b1, CTRL_OFS, 32'h0000_00D8);
		tx(b0, {2'b11, b0});
		bitc = 64;
		rem.send({2'b10, b0}, 10);
		rdx(DATA_OFS, {24'h0, b0});
		rdx(CTRL_OFS, 32'h0000_00DB);
		// Shift mode: send clocked out on txd, then receive idle line
		nb = 0;
		b0 = 8'($urandom);
		bus(1'b1, CTRL_OFS, 32'h0000_0000);
		tx(b0, {2'b00, b0});
		repeat (8) @(posedge ref_clk);
		rdx(CTRL_OFS, 32'h0000_0002);
		bus(1'b1, CTRL_OFS, 32'h0000_0010);
		repeat (110) @(posedge ref_clk);
		rdx(DATA_OFS, 32'h0000_00FF);
		rdx(CTRL_OFS, 32'h0000_0011);
		report_and_stop();
	end
endmodule
